/* File: hw/bfc_core.sv */
// Block feature classifier: eight feature-combination units with
// shadow and active threshold sets, and a four-wide feature-select table.
// Assumes frame_sync is an asynchronous pin, statistics on pclk, APB 32-bit.
`timescale 1ns/1ps

// Contract
// RULE_01: Select reads 256-entry one-bit lookup table
// RULE_02: Unit k match flag drives address bit k
// RULE_03: Missing units force their address bit zero
// RULE_04: Table four bits wide, 256 deep always
// RULE_05: Software loads all 256 table entries
// RULE_06: Member when table bit equals one
// RULE_07: Unit holds bounds, matches within them
// RULE_08: Forty-line threshold structure with fixed ranges
// RULE_09: Edge-mean bounds at lines 7, 0x1B
// RULE_10: Color bounds lines 0xC, 0x20 halves
// RULE_11: Software widens unused bounds fully
// RULE_12: Software computes block counts from resolution
// RULE_13: Bound comparisons inclusive at both ends
// RULE_14: Updates apply on sync fall when enabled
// RULE_15: Block size only 4,8,16,32,64
module bfc_core
	import bfc_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Frame timing pin
	input  wire logic        frame_sync,
	// Statistics in, result out
	input  wire bfc_stat_s   stat_in,
	output bfc_result_s      result_out,
	// Active geometry
	output logic      [15:0] hblk_out,
	output logic      [15:0] vblk_out,
	output logic      [31:0] tblk_out,
	output logic      [6:0]  bsize_out
);

	// Shadow (software) and active copies
	logic [31:0] thr_shadow [NUM_FCU][THR_LINES]; // Written by APB
	logic [31:0] thr_active [NUM_FCU][THR_LINES]; // Used by compare
	logic [3:0]  lut_shadow [LUT_DEPTH];          // Written by APB
	logic [3:0]  lut_active [LUT_DEPTH];          // Used by selects
	logic [1:0]  ctrl_reg;                        // Enable, update enable
	logic [15:0] hblk_reg;                        // Shadow geometry
	logic [15:0] vblk_reg;
	logic [31:0] tblk_reg;
	logic [6:0]  bsize_reg;
	logic [1:0]  sync_sr;                         // Two-stage synchroniser
	logic        sync_d;                          // Last synced level
	logic        sync_fall;                       // Falling edge pulse
	logic        commit;                          // Apply shadow copies
	logic [7:0]  match;                           // Unit match flags
	logic [7:0]  lut_addr;                        // Table index
	logic        wr_en;                           // APB write strobe
	logic        bsize_ok;                        // Legal block size

	// Zero-wait slave; every address answers OKAY
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign wr_en   = psel && penable && pwrite;

	// Synchronise frame_sync; only stage two feeds logic
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync_sr <= 2'h0;
			sync_d  <= 1'b0;
		end
		else
		begin
			sync_sr <= {sync_sr[0], frame_sync};
			sync_d  <= sync_sr[1];
		end
	end

	assign sync_fall = sync_d && !sync_sr[1];
	// Shadow copies move over only on the sync fall while enabled
	assign commit = sync_fall && ctrl_reg[CTRL_UPD]; // [RULE_14]

	// Accept only square block sides 4..64 in powers of two
	always_comb
	begin
		unique case (pwdata[6:0])
			7'h04, 7'h08, 7'h10, 7'h20, 7'h40: bsize_ok = 1'b1; // [RULE_15]
			default:                           bsize_ok = 1'b0;
		endcase
	end

	// Control and geometry shadow registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_reg  <= 2'h0;
			hblk_reg  <= 16'h0000;
			vblk_reg  <= 16'h0000;
			tblk_reg  <= RST_ZERO;
			bsize_reg <= RST_BSIZE;
		end
		else if (wr_en)
		begin
			// Illegal block sizes are ignored, old value kept
			unique case (paddr)
				OFS_CTRL:  ctrl_reg <= pwdata[1:0];
				OFS_HBLK:  hblk_reg <= pwdata[15:0];
				OFS_VBLK:  vblk_reg <= pwdata[15:0];
				OFS_TBLK:  tblk_reg <= pwdata;
				OFS_BSIZE: if (bsize_ok) bsize_reg <= pwdata[6:0]; // [RULE_15]
				default:   ;
			endcase
		end
	end

	// Active geometry taken on commit
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hblk_out  <= 16'h0000;
			vblk_out  <= 16'h0000;
			tblk_out  <= RST_ZERO;
			bsize_out <= RST_BSIZE;
		end
		else if (commit) // [RULE_14]
		begin
			hblk_out  <= hblk_reg;
			vblk_out  <= vblk_reg;
			tblk_out  <= tblk_reg;
			bsize_out <= bsize_reg;
		end
	end

	// Table storage; no reset so it can map onto block RAM
	always_ff @(posedge pclk)
	begin
		// Full 256 x 4 table exists whatever selects are used
		if (wr_en && paddr[11:10] == OFS_LUT[11:10]) // [RULE_04]
			lut_shadow[paddr[9:2]] <= pwdata[3:0];
		if (commit) // [RULE_14]
			lut_active <= lut_shadow;
	end

	// Threshold storage; lines 0x24-0x27 are forced to zero
	always_ff @(posedge pclk)
	begin
		if (wr_en && paddr[11] && paddr[7:2] < 6'(THR_LINES))
			thr_shadow[paddr[10:8]][paddr[7:2]] <=
				(paddr[7:2] >= LINE_ZERO) ? RST_ZERO : pwdata; // [RULE_08]
		if (commit) // [RULE_14]
			thr_active <= thr_shadow;
	end

	// Per-unit inclusive window test over every statistic line
	genvar gk;
	generate
		for (gk = 0; gk < NUM_FCU; gk++)
		begin : g_fcu
			logic [STAT_LINES-1:0] in_range; // Per line result
			always_comb
			begin
				for (int l = 0; l < STAT_LINES; l++)
				begin
					// Global lines 0-5 pair with 0x14, block lines with 0x1A
					// Edge line 7/0x1B and color line 0xC/0x20 follow
					// the same pairing, so per-byte windows cover them
					in_range[l] = 1'b1; // [RULE_09] [RULE_10]
					for (int b = 0; b < 4; b++)
						if (stat_in.line[l][b*8 +: 8] <
						    thr_active[gk][l][b*8 +: 8] ||
						    stat_in.line[l][b*8 +: 8] >
						    thr_active[gk][l+STAT_LINES][b*8 +: 8])
							in_range[l] = 1'b0; // [RULE_07] [RULE_13]
				end
			end
			// Absent units contribute a constant zero
			assign match[gk] = FCU_PRESENT[gk] && (&in_range); // [RULE_03]
		end
	endgenerate

	// Unit k drives address bit k
	assign lut_addr = match; // [RULE_02]

	// Registered result: table bit one means membership
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			result_out <= '0;
		else
		begin
			result_out.valid      <= stat_in.valid && ctrl_reg[CTRL_EN];
			result_out.fcu_match  <= lut_addr;
			result_out.fsu_member <= lut_active[lut_addr]; // [RULE_01] [RULE_06]
		end
	end

	// Read mux
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= RST_ZERO;
		else if (psel && !penable && !pwrite)
		begin
			if (paddr[11:10] == OFS_LUT[11:10])
				prdata <= {28'h0000000, lut_shadow[paddr[9:2]]};
			else if (paddr[11])
				prdata <= (paddr[7:2] < 6'(THR_LINES)) ?
					thr_shadow[paddr[10:8]][paddr[7:2]] : RST_ZERO;
			else
			begin
				unique case (paddr)
					OFS_CTRL:   prdata <= {30'h00000000, ctrl_reg};
					OFS_HBLK:   prdata <= {16'h0000, hblk_reg};
					OFS_VBLK:   prdata <= {16'h0000, vblk_reg};
					OFS_TBLK:   prdata <= tblk_reg;
					OFS_BSIZE:  prdata <= {25'h0000000, bsize_reg};
					OFS_STATUS: prdata <= {20'h00000, result_out.fsu_member,
						result_out.fcu_match};
					default:    prdata <= RST_ZERO;
				endcase
			end
		end
	end

	// Checks
	sequence s_fall;
		$past(sync_sr[1]) && !sync_sr[1];
	endsequence

	property p_commit;
		@(posedge pclk) disable iff (!presetn)
		s_fall and ctrl_reg[CTRL_UPD] |=> bsize_out == $past(bsize_reg);
	endproperty
	a_commit: assert property (p_commit) // [RULE_14]
		else $error("geometry not applied on sync fall");

	property p_hold;
		@(posedge pclk) disable iff (!presetn)
		!commit |=> $stable(hblk_out);
	endproperty
	a_hold: assert property (p_hold) // [RULE_14]
		else $error("geometry changed without commit");

	property p_bsize;
		@(posedge pclk) disable iff (!presetn)
		$onehot(bsize_reg) && bsize_reg >= 7'h04;
	endproperty
	a_bsize: assert property (p_bsize) // [RULE_15]
		else $error("illegal block size held");

	property p_member;
		@(posedge pclk) disable iff (!presetn)
		// Skip the release edge: the result flop was still held in reset
		presetn |=> result_out.fcu_match == $past(match);
	endproperty
	a_member: assert property (p_member) // [RULE_02]
		else $error("match flags not on table address");

	// A sync fall with updates off must leave the active copies alone
	property p_no_commit;
		@(posedge pclk) disable iff (!presetn)
		sync_fall && !ctrl_reg[CTRL_UPD] |=>
			$stable(bsize_out) && $stable(hblk_out);
	endproperty
	a_no_commit: assert property (p_no_commit) // [RULE_14]
		else $error("geometry applied with updates disabled");

	// Writes to reserved tail lines of a threshold structure store zero
	property p_zero_line;
		@(posedge pclk) disable iff (!presetn)
		wr_en && paddr[11] && paddr[7:2] >= LINE_ZERO &&
			paddr[7:2] < 6'(THR_LINES)
		|=> thr_shadow[$past(paddr[10:8])][$past(paddr[7:2])]
			== RST_ZERO;
	endproperty
	a_zero_line: assert property (p_zero_line) // [RULE_08]
		else $error("reserved threshold line not held at zero");

endmodule

/* File: hw/bfc_pkg.sv */
// Package for the block feature classifier: register map, field layout,
// threshold structure geometry and the carriers used by the core.
// Assumes a 32-bit APB master and a statistics stream on pclk.
package bfc_pkg;

	// Geometry of the classifier
	localparam int NUM_FCU   = 8;   // Feature-combination units
	localparam int NUM_FSU   = 4;   // Feature-select units
	localparam int LUT_DEPTH = 256; // Feature-select table entries
	localparam int THR_LINES = 40;  // Lines per threshold structure
	localparam int STAT_LINES = 20; // Statistic lines (6 global + 14 block)

	// Threshold structure line layout
	localparam logic [5:0] LINE_LO_GLOBAL = 6'h00; // Lower global 0x0-0x5
	localparam logic [5:0] LINE_LO_BLOCK  = 6'h06; // Lower block 0x6-0x13
	localparam logic [5:0] LINE_HI_GLOBAL = 6'h14; // Upper global 0x14-0x19
	localparam logic [5:0] LINE_HI_BLOCK  = 6'h1A; // Upper block 0x1A-0x23
	localparam logic [5:0] LINE_ZERO      = 6'h24; // Lines 0x24-0x27 are written as 0
	localparam logic [5:0] LINE_EDGE_LO   = 6'h07; // Edge-mean lower
	localparam logic [5:0] LINE_EDGE_HI   = 6'h1B; // Edge-mean upper
	localparam logic [5:0] LINE_COLOR_LO  = 6'h0C; // Color-select lower
	localparam logic [5:0] LINE_COLOR_HI  = 6'h20; // Color-select upper
	localparam int EDGE_MSB  = 15; // Edge-mean field position
	localparam int EDGE_LSB  = 8;
	localparam int COLOR_W   = 16; // Color select 1 low, 2 high

	// APB register byte offsets
	localparam logic [11:0] OFS_CTRL    = 12'h000; // Control
	localparam logic [11:0] OFS_HBLK    = 12'h004; // Horizontal blocks
	localparam logic [11:0] OFS_VBLK    = 12'h008; // Vertical blocks
	localparam logic [11:0] OFS_TBLK    = 12'h00C; // Total blocks
	localparam logic [11:0] OFS_BSIZE   = 12'h010; // Block size
	localparam logic [11:0] OFS_STATUS  = 12'h014; // Match status
	localparam logic [11:0] OFS_LUT     = 12'h400; // Table 0x400-0x7FC
	localparam logic [11:0] OFS_THR     = 12'h800; // FCU k at 0x800+k*0x100

	// Control fields
	localparam int CTRL_EN  = 0; // Core enable
	localparam int CTRL_UPD = 1; // Register update enable

	// Reset values
	localparam logic [31:0] RST_ZERO  = 32'h0000_0000;
	localparam logic [6:0]  RST_BSIZE = 7'h08;
	localparam logic [7:0]  FCU_PRESENT = 8'hFF; // Instantiated units mask

	// One block's statistics: 20 lines of 32 bits
	typedef struct packed {
		logic                        valid;
		logic [STAT_LINES-1:0][31:0] line;
	} bfc_stat_s;

	// Classification result for one block
	typedef struct packed {
		logic       valid;
		logic [7:0] fcu_match;
		logic [3:0] fsu_member;
	} bfc_result_s;

endpackage

/* File: tb/bfc_cpu_model.sv */
// Processor model: APB master that loads registers and tables.
// Assumes a slave that may add wait states; waits on pready only.
`timescale 1ns/1ps
module bfc_cpu_model
(
	// Clock
	input  wire logic        pclk,
	// APB master side
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [11:0] paddr,
	output logic      [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready
);
	// Idle bus from time zero
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
	end

	// One transfer; request held until pready is seen high
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the classifier core.
// Assumes the processor model drives APB and the bench drives the rest.
`timescale 1ns/1ps
module testbench
	import bfc_pkg::*;
;
	logic        pclk, presetn, frame_sync;
	logic        psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] hblk_out, vblk_out;
	logic [31:0] tblk_out;
	logic [6:0]  bsize_out;
	bfc_stat_s   stat_in;
	bfc_result_s result_out;
	int          failures, checks;
	// Stimulus words: edge, color low, color high, line 6 byte
	logic [31:0] vec [6] = '{32'h2104_0000, 32'h5310_1200, 32'h5404_0500,
		32'h2004_0507, 32'h6204_0502, 32'h4003_0500};

	bfc_cpu_model u_cpu (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready);
	bfc_core u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .frame_sync, .stat_in,
		.result_out, .hblk_out, .vblk_out, .tblk_out, .bsize_out);

	// 250 MHz clock
	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task automatic chk(input string n, input logic [31:0] e, s);
		checks++;
		if (s !== e)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		u_cpu.xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [11:0] a);
		u_cpu.xfer(1'b0, a, 32'h0000_0000, q);
	endtask
	// Sync pulse; falling edge is seen three clocks later
	task automatic commit();
		@(posedge pclk);
		frame_sync <= 1'b1;
		repeat (3) @(posedge pclk);
		frame_sync <= 1'b0;
		repeat (6) @(posedge pclk);
	endtask
	// Select table: OR of first two units, unit 2, unit 7, all
	function automatic logic [3:0] lut(logic [7:0] a);
		return {&a, a[7], a[2], a[0] | a[1]};
	endfunction
	// Expected match flags, bounds inclusive
	function automatic logic [7:0] fcm(logic [31:0] v);
		logic [7:0] m;
		m[0] = v[31:24] >= 8'h21 && v[31:24] <= 8'h53
			&& v[23:16] >= 8'h04 && v[23:16] <= 8'h10;
		m[1] = v[31:24] >= 8'h32 && v[31:24] <= 8'h61
			&& v[15:8] >= 8'h05 && v[15:8] <= 8'h12;
		for (int k = 2; k < 8; k++)
			m[k] = (v[7:0] == 8'(k));
		return m;
	endfunction
	function automatic bfc_stat_s mkstat(logic [31:0] v);
		bfc_stat_s s;
		s = '0;
		s.valid = 1'b1;
		s.line[6] = {24'h00_0000, v[7:0]};
		s.line[7] = {16'h0000, v[31:24], 8'h00};
		s.line[12] = {8'h00, v[15:8], 8'h00, v[23:16]};
		return s;
	endfunction
	// Threshold line n of unit k; unused bounds widest
	function automatic logic [31:0] thr(int k, int n);
		logic [31:0] t;
		t = (n < 20) ? 32'h0000_0000 : 32'hFFFF_FFFF;
		if (k >= 2 && n == 6)
			t = 32'(k);
		if (k >= 2 && n == 26)
			t = 32'hFFFF_FF00 | 32'(k);
		if (k < 2)
			case (n)
				7:  t = k ? 32'h0000_3200 : 32'h0000_2100;
				12: t = k ? 32'h0005_0000 : 32'h0000_0004;
				27: t = k ? 32'h0000_6100 : 32'h0000_5300;
				32: t = k ? 32'h0012_FFFF : 32'hFFFF_0010;
				default: ;
			endcase
		return t;
	endfunction
	function automatic logic [11:0] ta(int k, int n);
		return 12'(OFS_THR + k * 256 + 4 * n);
	endfunction

	initial
	begin
		failures = 0;
		checks = 0;
		presetn = 1'b0;
		frame_sync = 1'b0;
		stat_in = '0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		chk("bsize_rst", 32'(RST_BSIZE), 32'(bsize_out));
		chk("hblk_rst", 32'h0, 32'(hblk_out));
		wr(OFS_CTRL, 32'h0000_0000);
		wr(OFS_HBLK, 32'h0000_00A0);
		wr(OFS_VBLK, 32'h0000_005A);
		wr(OFS_TBLK, 32'h0000_3840);
		wr(OFS_BSIZE, 32'h0000_0005);
		commit();
		chk("hblk_held", 32'h0, 32'(hblk_out));
		wr(OFS_CTRL, 32'h0000_0003);
		commit();
		chk("hblk", 32'h0000_00A0, 32'(hblk_out));
		chk("vblk", 32'h0000_005A, 32'(vblk_out));
		chk("tblk", 32'h0000_3840, tblk_out);
		chk("bsize_bad", 32'h8, 32'(bsize_out));
		wr(OFS_BSIZE, 32'h0000_0040);
		for (int k = 0; k < 8; k++)
			for (int n = 0; n < 40; n++)
				wr(ta(k, n), thr(k, n));
		for (int a = 0; a < 256; a++)
			wr(12'(OFS_LUT + 4 * a), 32'(lut(8'(a))));
		commit();
		chk("bsize", 32'h40, 32'(bsize_out));
		rd(ta(0, 7));
		chk("edge_lo", 32'h0000_2100, q);
		rd(ta(1, 32));
		chk("color_hi", 32'h0012_FFFF, q);
		rd(ta(0, 36));
		chk("zero_line", 32'h0000_0000, q);
		rd(12'(OFS_LUT + 4 * 255));
		chk("lut_ff", 32'h0000_000F, q);
		rd(12'h018);
		chk("unmapped", 32'h0000_0000, q);
		chk("pslverr", 32'h0, 32'(pslverr));
		chk("pready", 32'h1, 32'(pready));
		foreach (vec[i])
		begin
			@(posedge pclk);
			stat_in <= mkstat(vec[i]);
			@(posedge pclk);
			#1;
			chk("valid", 32'h1, 32'(result_out.valid));
			chk("fcu", 32'(fcm(vec[i])), 32'(result_out.fcu_match));
			chk("fsu", 32'(lut(fcm(vec[i]))), 32'(result_out.fsu_member));
		end
		rd(OFS_STATUS);
		chk("status", {20'h0, lut(8'h02), 8'h02}, q);
		// Reset in mid-run: geometry returns to reset values, enable clears, tables are kept
		@(posedge pclk);
		stat_in <= mkstat(32'h0000_0000);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		chk("hblk_rst2", 32'h0, 32'(hblk_out));
		chk("bsize_rst2", 32'(RST_BSIZE), 32'(bsize_out));
		@(posedge pclk);
		#1;
		chk("valid_off", 32'h0, 32'(result_out.valid));
		final_report();
	end

	// Hang guard
	initial
	begin
		#100000;
		failures++;
		final_report();
	end

	task automatic final_report();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
endmodule
